// >>> rtl/lebs_lane_map.sv
// beat decoder: external address, lane selects and last-beat flag
`timescale 1ns/1ps
`default_nettype none
module lebs_lane_map (
  input  wire logic       write,
  input  wire logic [2:0] size,
  input  wire logic [2:0] addr,
  input  wire logic [2:0] beat,
  output logic [2:0]      ext_addr,
  output logic [3:0]      lanes_n,
  output logic            last
);
  import lebs_pkg::*;
  always_comb begin
    ext_addr = addr;
    lanes_n  = LEBS_LANES_ALL;
    last     = 1'b1;
    if (write) begin
      // 8-bit bus: only lane 0 ever carries data
      lanes_n = LEBS_LANES_BYTE;
      case (size)
        LEBS_SIZE_DWORD: begin
          ext_addr = ~beat;
          last     = (beat == 3'h7);
        end
        LEBS_SIZE_WORD: begin
          ext_addr = {addr[2], ~beat[1:0]};
          last     = (beat == 3'h3);
        end
        LEBS_SIZE_HALF: begin
          ext_addr = {addr[2:1], ~beat[0]};
          last     = (beat == 3'h1);
        end
        default: begin
          ext_addr = addr;
          last     = 1'b1;
        end
      endcase
    end else begin
      case (size)
        LEBS_SIZE_DWORD: begin
          ext_addr = {2'h0, ~beat[0]};
          last     = (beat == 3'h1);
        end
        LEBS_SIZE_WORD: begin
          ext_addr = {2'h0, addr[2]};
        end
        LEBS_SIZE_HALF: begin
          ext_addr = {2'h0, addr[2]};
          lanes_n  = addr[1] ? LEBS_LANES_HI : LEBS_LANES_LO;
        end
        default: begin
          ext_addr = {2'h0, addr[2]};
          lanes_n  = ~(4'h1 << addr[1:0]);
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> rtl/lebs_pkg.sv
// constants for little-endian external bus lane steering
// Operation
// - dword read, 32-bit bus: two beats, all lanes, upper word first
// - word read: ext addr bit0 follows sys addr bit2, all lanes active
// - halfword read: addr bit0 from bit2, lanes 0011 or 1100 by bit1
// - byte read: one lane low chosen by addr 1:0, byte to addressed lane
// - dword write, 8-bit bus: eight beats, addresses 111 down to 000
// - word write: four descending beats in addressed half; halfword two beats
package lebs_pkg;
  localparam logic [2:0] LEBS_SIZE_BYTE  = 3'h0;
  localparam logic [2:0] LEBS_SIZE_HALF  = 3'h1;
  localparam logic [2:0] LEBS_SIZE_WORD  = 3'h2;
  localparam logic [2:0] LEBS_SIZE_DWORD = 3'h3;
  localparam logic [3:0] LEBS_LANES_ALL  = 4'h0;
  localparam logic [3:0] LEBS_LANES_NONE = 4'hF;
  localparam logic [3:0] LEBS_LANES_LO   = 4'hC;
  localparam logic [3:0] LEBS_LANES_HI   = 4'h3;
  localparam logic [3:0] LEBS_LANES_BYTE = 4'hE;
  localparam logic [2:0] LEBS_ADDR_RST   = 3'h0;
  localparam logic [31:0] LEBS_DOUT_RST  = 32'h0;
  localparam logic [63:0] LEBS_RDATA_RST = 64'h0;
  localparam logic [2:0] LEBS_BEAT_RST   = 3'h0;
  typedef enum logic [0:0] {LEBS_IDLE, LEBS_BEAT} lebs_state_type;
endpackage

// >>> rtl/lebs_steer.sv
// lane steering engine: splits system transfers into external beats
`timescale 1ns/1ps
`default_nettype none
module lebs_steer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [2:0]  req_size,
  input  wire logic [2:0]  req_addr,
  input  wire logic [63:0] req_wdata,
  input  wire logic        beat_done,
  input  wire logic [31:0] ext_mem_data_in,
  output logic             req_ready,
  output logic             beat_active,
  output logic [2:0]       ext_addr_out,
  output logic [3:0]       ext_byte_lane_sel_n,
  output logic [31:0]      ext_mem_data_out,
  output logic             ext_mem_data_oe,
  output logic [63:0]      rd_data,
  output logic             xfer_done
);
  import lebs_pkg::*;

  lebs_state_type state_r;
  lebs_state_type state_nxt;
  logic        write_r;
  logic        write_nxt;
  logic [2:0]  size_r;
  logic [2:0]  size_nxt;
  logic [2:0]  addr_r;
  logic [2:0]  addr_nxt;
  logic [63:0] wdata_r;
  logic [63:0] wdata_nxt;
  logic [2:0]  beat_r;
  logic [2:0]  beat_nxt;
  logic [2:0]  eaddr_r;
  logic [3:0]  lanes_r;
  logic [3:0]  lanes_nxt;
  logic [31:0] dout_r;
  logic [31:0] dout_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic        active_r;
  logic        active_nxt;
  logic        ready_r;
  logic        ready_nxt;
  logic        done_r;
  logic        done_nxt;
  logic [63:0] rdata_r;
  logic [63:0] rdata_nxt;
  logic [2:0]  eaddr_nxt;
  logic [2:0]  map_addr;
  logic [3:0]  map_lanes;
  logic        map_last;
  logic        last_r;
  logic        last_nxt;
  logic        rd_cap;
  logic        accept;

  // sizes above doubleword have no mapping, so they are never taken
  assign accept = (state_r == LEBS_IDLE) && req_valid && (req_size <= LEBS_SIZE_DWORD);

  // decoder sees the next beat so its answer lands in the output flops
  lebs_lane_map u_map (
    .write    (write_nxt),
    .size     (size_nxt),
    .addr     (addr_nxt),
    .beat     (beat_nxt),
    .ext_addr (map_addr),
    .lanes_n  (map_lanes),
    .last     (map_last)
  );

  // request group: the transfer is held for its whole life
  always_comb begin
    write_nxt = write_r;
    size_nxt  = size_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    if (accept) begin
      write_nxt = req_write;
      size_nxt  = req_size;
      addr_nxt  = req_addr;
      wdata_nxt = req_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_r <= 1'b0;
      size_r  <= LEBS_SIZE_BYTE;
      addr_r  <= LEBS_ADDR_RST;
      wdata_r <= LEBS_RDATA_RST;
    end else begin
      write_r <= write_nxt;
      size_r  <= size_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // sequencer group: a beat ends only on the memory's say-so
  always_comb begin
    state_nxt = state_r;
    beat_nxt  = beat_r;
    done_nxt  = 1'b0;
    case (state_r)
      LEBS_IDLE: begin
        if (accept) begin
          state_nxt = LEBS_BEAT;
          beat_nxt  = LEBS_BEAT_RST;
        end
      end
      LEBS_BEAT: begin
        if (beat_done) begin
          if (last_r) begin
            state_nxt = LEBS_IDLE;
            done_nxt  = 1'b1;
          end else begin
            beat_nxt = beat_r + 3'h1;
          end
        end
      end
      default: begin
        state_nxt = LEBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= LEBS_IDLE;
      beat_r  <= LEBS_BEAT_RST;
      done_r  <= 1'b0;
      last_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      beat_r  <= beat_nxt;
      done_r  <= done_nxt;
      last_r  <= last_nxt;
    end
  end

  // output group: decoder answer for the coming beat, parked values when idle
  always_comb begin
    active_nxt = (state_nxt == LEBS_BEAT);
    ready_nxt  = (state_nxt == LEBS_IDLE);
    last_nxt   = map_last && active_nxt;
    eaddr_nxt  = active_nxt ? map_addr : LEBS_ADDR_RST;
    lanes_nxt  = active_nxt ? map_lanes : LEBS_LANES_NONE;
    oe_nxt     = active_nxt && write_nxt;
    // byte at the external address rides lane 0
    dout_nxt   = oe_nxt ? {24'h0, wdata_nxt[{map_addr, 3'h0} +: 8]} : LEBS_DOUT_RST;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eaddr_r  <= LEBS_ADDR_RST;
      lanes_r  <= LEBS_LANES_NONE;
      dout_r   <= LEBS_DOUT_RST;
      oe_r     <= 1'b0;
      active_r <= 1'b0;
      ready_r  <= 1'b1;
    end else begin
      eaddr_r  <= eaddr_nxt;
      lanes_r  <= lanes_nxt;
      dout_r   <= dout_nxt;
      oe_r     <= oe_nxt;
      active_r <= active_nxt;
      ready_r  <= ready_nxt;
    end
  end

  // read data group: sampled only in the cycle the memory ends a read beat
  assign rd_cap = (state_r == LEBS_BEAT) && beat_done && !write_r;

  // beat with external address bit 0 set fills the upper word
  // only bytes whose lane is selected are written
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_rbyte
      always_comb begin
        rdata_nxt[gi*8 +: 8] = rdata_r[gi*8 +: 8];
        if (rd_cap && !lanes_r[gi % 4] && (eaddr_r[0] == (gi >= 4))) begin
          rdata_nxt[gi*8 +: 8] = ext_mem_data_in[(gi % 4)*8 +: 8];
        end
      end
    end
  endgenerate

  // cleared only by reset: a narrow read keeps the other bytes of the last result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= LEBS_RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign req_ready           = ready_r;
  assign beat_active         = active_r;
  assign ext_addr_out        = eaddr_r;
  assign ext_byte_lane_sel_n = lanes_r;
  assign ext_mem_data_out    = dout_r;
  assign ext_mem_data_oe     = oe_r;
  assign rd_data             = rdata_r;
  assign xfer_done           = done_r;
endmodule
`default_nettype wire

// >>> testbench/lebs_mem_model.sv
// external memory model on the narrow data bus
`timescale 1ns/1ps
`default_nettype none
module lebs_mem_model (
  input  wire logic        clk,
  input  wire logic        beat_active,
  input  wire logic [2:0]  ext_addr_out,
  output logic             beat_done,
  output logic [31:0]      ext_mem_data_in
);
  logic [1:0]  cnt;
  logic        slow;
  logic [31:0] word;
  assign word = ext_addr_out[0] ? 32'h8877_6655 : 32'h4433_2211;
  // outside a beat the bus shows garbage, not the last word
  assign ext_mem_data_in = beat_active ? word : ~word;
  initial begin
    cnt = 2'h0;
    slow = 1'b0;
    beat_done = 1'b0;
  end
  // alternate prompt and slow beats
  always @(posedge clk) begin
    beat_done <= 1'b0;
    if (beat_active && !beat_done) begin
      if (cnt == (slow ? 2'h3 : 2'h0)) begin
        beat_done <= 1'b1;
        cnt <= 2'h0;
        slow <= !slow;
      end else
        cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/lebs_steer_monitor.sv
// assertions on the lane steering ports
`timescale 1ns/1ps
`default_nettype none
module lebs_steer_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [2:0]  req_size,
  input wire logic [2:0]  req_addr,
  input wire logic [63:0] req_wdata,
  input wire logic        req_ready,
  input wire logic        beat_done,
  input wire logic        beat_active,
  input wire logic [2:0]  ext_addr_out,
  input wire logic [3:0]  ext_byte_lane_sel_n,
  input wire logic [31:0] ext_mem_data_out,
  input wire logic        ext_mem_data_oe
);
  import lebs_pkg::*;
  logic        take;
  logic        a1;
  logic [3:0]  lanes_e;
  logic [63:0] wd_r;
  assign take = req_valid && req_ready && req_size <= LEBS_SIZE_DWORD;
  assign a1 = req_addr[1];
  assign lanes_e = req_size == LEBS_SIZE_BYTE ? ~(4'h1 << req_addr[1:0])
                 : req_size == LEBS_SIZE_HALF ? {~a1, ~a1, a1, a1} : 4'h0;
  always_ff @(posedge clk or posedge rst)
    if (rst) wd_r <= 64'h0;
    else if (take) wd_r <= req_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_idle; !beat_active |-> ext_byte_lane_sel_n == LEBS_LANES_NONE; endproperty
  a_idle: assert property (p_idle) else $error("lanes on while idle");
  property p_rd1; take && !req_write && req_size == LEBS_SIZE_DWORD
    |=> ext_addr_out == 3'h1 && ext_byte_lane_sel_n == LEBS_LANES_ALL; endproperty
  a_rd1: assert property (p_rd1) else $error("dword read beat");
  property p_rd; take && !req_write && req_size != LEBS_SIZE_DWORD |=> ext_addr_out
    == {2'h0, $past(req_addr[2])} && ext_byte_lane_sel_n == $past(lanes_e); endproperty
  a_rd: assert property (p_rd) else $error("read beat");
  property p_dw; take && req_write && req_size == LEBS_SIZE_DWORD |=> ext_addr_out == 3'h7;
  endproperty
  a_dw: assert property (p_dw) else $error("dword write start");
  property p_wd; take && req_write && req_size == LEBS_SIZE_WORD
    |=> ext_addr_out == {$past(req_addr[2]), 2'h3}; endproperty
  a_wd: assert property (p_wd) else $error("word write start");
  property p_step; ext_mem_data_oe && beat_done
    |=> !beat_active || ext_addr_out == $past(ext_addr_out) - 3'h1; endproperty
  a_step: assert property (p_step) else $error("write step");
  property p_wdat; ext_mem_data_oe |-> ext_byte_lane_sel_n == LEBS_LANES_BYTE
    && ext_mem_data_out == {24'h0, wd_r[{ext_addr_out, 3'h0} +: 8]}; endproperty
  a_wdat: assert property (p_wdat) else $error("write byte");
endmodule
bind lebs_steer lebs_steer_monitor u_mon (.*);
`default_nettype wire

// >>> testbench/lebs_steer_tb.sv
// testbench for the lane steering block
`timescale 1ns/1ps
`default_nettype none
module lebs_steer_tb;
  import lebs_pkg::*;
  logic        clk, rst, req_valid, req_write, beat_done;
  logic        req_ready, beat_active, ext_mem_data_oe, xfer_done;
  logic [2:0]  req_size, req_addr, ext_addr_out;
  logic [3:0]  ext_byte_lane_sel_n;
  logic [31:0] ext_mem_data_in, ext_mem_data_out;
  logic [63:0] req_wdata, rd_data, exp_rd;
  int          n_fail, total_checks;
  lebs_steer DUT (.*);
  lebs_mem_model u_mem (.clk, .beat_active, .ext_addr_out, .beat_done, .ext_mem_data_in);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic xfer(logic w, logic [2:0] sz, a, a0, logic [3:0] nb, lanes);
    logic [3:0] i;
    logic [2:0] e;
    int k;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_size <= sz;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    i = 4'h0;
    for (k = 0; k < 60 && xfer_done !== 1'b1; k++) begin
      @(negedge clk);
      if (beat_active && beat_done) begin
        e = a0 - i[2:0];
        check("addr", ext_addr_out, e);
        check("lanes", ext_byte_lane_sel_n, lanes);
        check("oe", ext_mem_data_oe, w);
        if (w) check("wdata", ext_mem_data_out, req_wdata[{e, 3'h0} +: 8]);
        else for (int b = 0; b < 4; b++)
          if (!lanes[b]) exp_rd[{e[0], 2'(b), 3'h0} +: 8] = ext_mem_data_in[b*8 +: 8];
        i++;
      end
    end
    if (k == 60) begin
      n_fail++;
      return;
    end
    check("beats", i, nb);
    check("ready", req_ready, 1'b1);
    if (!w) check("rd_data", rd_data, exp_rd);
  endtask
  // single bytes first so untouched bytes stay visibly zero
  task automatic t_reads;
    for (int a = 0; a < 8; a++) xfer(0, 0, 3'(a), 3'(a >> 2), 1, ~(4'h1 << a[1:0]));
    for (int a = 0; a < 8; a += 2) xfer(0, 1, 3'(a), 3'(a >> 2), 1, a[1] ? 4'h3 : 4'hC);
    xfer(0, 2, 3'h4, 3'h1, 1, 4'h0);
    xfer(0, 2, 3'h0, 3'h0, 1, 4'h0);
    xfer(0, 3, 3'h0, 3'h1, 2, 4'h0);
  endtask
  // oversize requests must never start a beat
  task automatic t_refuse;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= 1'b0;
    req_size <= 3'h4;
    repeat (3) @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    check("refused", beat_active, 1'b0);
    check("refused ready", req_ready, 1'b1);
  endtask
  task automatic t_writes;
    xfer(1, 3, 3'h0, 3'h7, 8, 4'hE);
    xfer(1, 2, 3'h4, 3'h7, 4, 4'hE);
    xfer(1, 2, 3'h0, 3'h3, 4, 4'hE);
    xfer(1, 1, 3'h6, 3'h7, 2, 4'hE);
    xfer(1, 0, 3'h5, 3'h5, 1, 4'hE);
  endtask
  initial begin
    n_fail = 0;
    total_checks = 0;
    exp_rd = 64'h0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_size = 3'h0;
    req_addr = 3'h0;
    req_wdata = 64'hF0E1_D2C3_B4A5_9687;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reads();
    t_refuse();
    t_writes();
    close_out();
  end
endmodule
`default_nettype wire
